// ---- core/bls_cfg.svh ----
`ifndef BLS_CFG_SVH
`define BLS_CFG_SVH
// ==========================================================
// port addresses
`define BLS_LED_PORT_ADDR 16'h0456
`define BLS_RST_PORT_ADDR 16'h0457
// ==========================================================
// led control field layout
`define BLS_LED_AUTO_VAL 8'h00
`define BLS_LED_OFF_VAL 8'h08
`define BLS_LED_MAN_BIT 3
`define BLS_LED_RGB_MSB 2
`define BLS_LED_RED_BIT 2
`define BLS_LED_GRN_BIT 1
`define BLS_LED_BLU_BIT 0
`define BLS_LED_EE_CS_BIT 7
`define BLS_LED_EE_SK_BIT 6
`define BLS_LED_EE_DI_BIT 5
`define BLS_LED_EE_DO_BIT 4
`define BLS_LED_RESET_VAL 8'h00
`define BLS_LED_WR_MASK 8'he7
// ==========================================================
// reset status field layout
`define BLS_RST_MAIN_BIT 7
`define BLS_RST_CORE_BIT 6
`define BLS_RST_NSTBY_BIT 5
`define BLS_RST_MEM_BIT 4
`define BLS_RST_STBY_BIT 3
`define BLS_RST_PCI_BIT 1
`define BLS_RST_UTIL_BIT 0
`define BLS_RST_VALID_MASK 8'hfb
`define BLS_RST_RESET_VAL 8'h00
// ==========================================================
// timing
`define BLS_CLK_PERIOD_NS 10
`define BLS_BLINK_MS 100
`define BLS_BLINK_CYCLES ((`BLS_BLINK_MS * 1000000) / `BLS_CLK_PERIOD_NS)
`endif

// ---- core/bls_pkg.sv ----
package bls_pkg;
  // ==========================================================
  // board conditions that steer the automatic colour
  typedef struct packed {
    logic in_reset;
    logic standby;
    logic thermal_near;
    logic disk_active;
    logic link_10;
    logic link_100;
    logic net_active;
  } bls_board_cond_t;
  // ==========================================================
  // raw reset source levels, one per status bit
  typedef struct packed {
    logic main_5v;
    logic core_supply;
    logic non_standby;
    logic memory_supply;
    logic standby_supply;
    logic pci_reset;
    logic util_button;
  } bls_rst_src_t;
  // ==========================================================
  // wake source levels and enables
  typedef struct packed {
    logic ring_a;
    logic ring_b;
    logic dio_event;
    logic pm_event;
  } bls_wake_t;
  typedef struct packed {
    logic r;
    logic g;
    logic b;
  } bls_rgb_t;
  typedef enum logic [1:0] {
    BLS_PWR_ON,
    BLS_PWR_SLEEP_S1,
    BLS_PWR_SLEEP_S3,
    BLS_PWR_SOFT_OFF
  } bls_pwr_t;
endpackage : bls_pkg

// ---- core/bls_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// two-flop synchroniser for a bundle of pin levels
module bls_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : bls_sync
`default_nettype wire

// ---- core/bls_rst_record.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "bls_cfg.svh"
// ==========================================================
// sticky reset source record with priority spreading
module bls_rst_record (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // synchronised sources and configuration
  input wire bls_pkg::bls_rst_src_t src_in,
  input wire logic button_is_reset_in,
  // write one to clear
  input wire logic clr_we_in,
  input wire logic [7:0] clr_data_in,
  // record
  output logic [7:0] status_out
);
  logic [7:0] hit;
  logic [7:0] status_next;
  logic prio1;
  logic prio2;
  logic prio3;
  logic prio4;
  // a source also marks every source of larger priority number;
  // sources sharing one number leave each other alone
  assign prio1 = src_in.standby_supply;
  assign prio2 = prio1 | src_in.main_5v;
  assign prio3 = src_in.core_supply | src_in.non_standby | src_in.memory_supply;
  assign prio4 = prio2 | prio3 | src_in.pci_reset;
  always_comb begin
    hit = 8'h00;
    hit[`BLS_RST_STBY_BIT] = prio1;
    hit[`BLS_RST_MAIN_BIT] = prio2;
    hit[`BLS_RST_CORE_BIT] = prio2 | src_in.core_supply;
    hit[`BLS_RST_NSTBY_BIT] = prio2 | src_in.non_standby;
    hit[`BLS_RST_MEM_BIT] = prio2 | src_in.memory_supply;
    hit[`BLS_RST_PCI_BIT] = prio4;
    // button has no priority; masked when it serves another function
    hit[`BLS_RST_UTIL_BIT] = src_in.util_button & button_is_reset_in;
  end
  // set wins over a simultaneous clear
  assign status_next = (((clr_we_in ? (status_out & ~clr_data_in) : status_out) | hit)
                        & `BLS_RST_VALID_MASK);
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_out <= `BLS_RST_RESET_VAL;
    end else begin
      status_out <= status_next;
    end
  end
endmodule : bls_rst_record
`default_nettype wire

// ---- core/bls_top.sv ----
// How it works
// - auto: green, blue disk, cyan/magenta link, blink
// - auto: red reset, yellow standby, white thermal
// - auto: jumper at power-up forces red
// - writing zero selects automatic colour
// - manual values drive red, green, blue enables
// - writing 0x08 turns led off
// - status bit set when source asserted
// - write one clears, zero keeps
// - fixed bit assignment of reset sources
// - sources carry priority numbers one to four
// - source also records all higher numbers
// - non-reset button never sets its bit
// - suspend button enters enabled s1/s3
// - enabled ring indicator wakes from sleep
// - enabled digital io event wakes, even s5
// - enabled power event input wakes system
// - drive open-drain active-low supply request
// - monitor supplies, generate power good
`timescale 1ns/1ns
`default_nettype none
`include "bls_cfg.svh"
module bls_top (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // i/o port access
  input wire logic [15:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  // eeprom lines sharing the led port
  input wire logic ee_data_in,
  output logic ee_cs_out,
  output logic ee_sk_out,
  output logic ee_di_out,
  // board condition pins
  input wire bls_pkg::bls_board_cond_t cond_in,
  input wire logic default_settings_jumper_in,
  // reset source pins
  input wire bls_pkg::bls_rst_src_t rst_src_in,
  // power and wake pins
  input wire logic power_button_in,
  input wire logic supplies_ok_in,
  input wire bls_pkg::bls_wake_t wake_in,
  // configuration from firmware setup
  input wire logic button_is_reset_in,
  input wire logic button_is_suspend_in,
  input wire logic s1_enable_in,
  input wire logic s3_enable_in,
  input wire logic soft_off_req_in,
  input wire bls_pkg::bls_wake_t wake_en_in,
  // led
  output logic led_red_out,
  output logic led_green_out,
  output logic led_blue_out,
  // power control
  output logic supply_on_request_n_out,
  output logic supply_on_request_n_oe_out,
  output logic power_good_out,
  output bls_pkg::bls_pwr_t power_state_out
);
  // ==========================================================
  // pin synchronisation
  localparam int PIN_W = 7 + 7 + 1 + 1 + 1 + 1 + 4;
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_sync;
  bls_pkg::bls_board_cond_t cond_s;
  bls_pkg::bls_rst_src_t rst_src_s;
  bls_pkg::bls_wake_t wake_s;
  logic jumper_s;
  logic button_s;
  logic supplies_ok_s;
  logic ee_data_s;
  assign pins_raw = {cond_in, rst_src_in, default_settings_jumper_in, power_button_in,
                     supplies_ok_in, ee_data_in, wake_in};
  bls_sync #(
    .WIDTH(PIN_W)
  ) u_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );
  assign {cond_s, rst_src_s, jumper_s, button_s, supplies_ok_s, ee_data_s, wake_s} = pins_sync;
  // ==========================================================
  // port decode
  logic led_sel;
  logic rst_sel;
  logic led_we;
  logic rst_we;
  assign led_sel = (io_addr_in == `BLS_LED_PORT_ADDR);
  assign rst_sel = (io_addr_in == `BLS_RST_PORT_ADDR);
  assign led_we = io_wr_in & led_sel;
  assign rst_we = io_wr_in & rst_sel;
  // ==========================================================
  // led / eeprom control register
  logic [7:0] led_ctrl_reg;
  logic [7:0] led_ctrl_next;
  // reserved bits 4 and 3 not stored; bit 3 is a manual flag rebuilt from the value
  assign led_ctrl_next = led_we ? (io_wdata_in & `BLS_LED_WR_MASK) | {4'h0,
                         (io_wdata_in[`BLS_LED_MAN_BIT] & (io_wdata_in != `BLS_LED_AUTO_VAL)),
                         3'h0} : led_ctrl_reg;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      led_ctrl_reg <= `BLS_LED_RESET_VAL;
    end else begin
      led_ctrl_reg <= led_ctrl_next;
    end
  end
  logic manual_mode;
  assign manual_mode = led_ctrl_reg[`BLS_LED_MAN_BIT];
  // ==========================================================
  // reset source record
  logic [7:0] rst_status;
  bls_rst_record u_rst (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .src_in(rst_src_s),
    .button_is_reset_in(button_is_reset_in),
    .clr_we_in(rst_we),
    .clr_data_in(io_wdata_in),
    .status_out(rst_status)
  );
  // ==========================================================
  // jumper caught at power-up
  logic jumper_red_reg;
  logic [1:0] settle_reg;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      jumper_red_reg <= 1'b0;
      settle_reg <= 2'h0;
    end else begin
      // synchroniser shows its reset zero for two edges; wait it out
      if (settle_reg != 2'h3) begin
        settle_reg <= settle_reg + 2'h1;
      end
      // sampled once per power-up; held until the next power-up
      if (settle_reg == 2'h2) begin
        jumper_red_reg <= jumper_s;
      end
    end
  end
  // ==========================================================
  // activity blink
  localparam logic [23:0] BLINK_CYC = 24'(`BLS_BLINK_CYCLES);
  logic [23:0] blink_cnt_reg;
  logic blink_phase_reg;
  logic blink_wrap;
  assign blink_wrap = (blink_cnt_reg == BLINK_CYC - 24'h000001);
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      blink_cnt_reg <= 24'h000000;
      blink_phase_reg <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_wrap ? 24'h000000 : blink_cnt_reg + 24'h000001;
      if (blink_wrap) begin
        blink_phase_reg <= ~blink_phase_reg;
      end
    end
  end
  // ==========================================================
  // power state
  bls_pkg::bls_pwr_t pwr_reg;
  bls_pkg::bls_pwr_t pwr_next;
  logic button_d_reg;
  logic button_press;
  logic ring_wake;
  logic dio_wake;
  logic pme_wake;
  logic low_power;
  logic any_wake;
  assign button_press = button_s & ~button_d_reg;
  assign low_power = (pwr_reg != bls_pkg::BLS_PWR_ON);
  assign ring_wake = (wake_s.ring_a & wake_en_in.ring_a)
                   | (wake_s.ring_b & wake_en_in.ring_b);
  assign dio_wake = wake_s.dio_event & wake_en_in.dio_event;
  assign pme_wake = wake_s.pm_event & wake_en_in.pm_event;
  // ring only from sleep states; digital io and power event also from soft off
  assign any_wake = dio_wake | pme_wake
                  | (ring_wake & (pwr_reg != bls_pkg::BLS_PWR_SOFT_OFF));
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      bls_pkg::BLS_PWR_ON: begin
        if (soft_off_req_in) begin
          pwr_next = bls_pkg::BLS_PWR_SOFT_OFF;
        end else if (button_press & button_is_suspend_in & s3_enable_in) begin
          pwr_next = bls_pkg::BLS_PWR_SLEEP_S3;
        end else if (button_press & button_is_suspend_in & s1_enable_in) begin
          pwr_next = bls_pkg::BLS_PWR_SLEEP_S1;
        end
      end
      bls_pkg::BLS_PWR_SLEEP_S1,
      bls_pkg::BLS_PWR_SLEEP_S3,
      bls_pkg::BLS_PWR_SOFT_OFF: begin
        if (any_wake) begin
          pwr_next = bls_pkg::BLS_PWR_ON;
        end
      end
    endcase
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_reg <= bls_pkg::BLS_PWR_ON;
      button_d_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      button_d_reg <= button_s;
    end
  end
  // ==========================================================
  // led colour selection
  bls_pkg::bls_rgb_t auto_rgb;
  bls_pkg::bls_rgb_t man_rgb;
  bls_pkg::bls_rgb_t led_rgb;
  always_comb begin
    // priority: reset/jumper over thermal over standby over activity
    if (cond_s.in_reset | jumper_red_reg) begin
      auto_rgb = '{r: 1'b1, g: 1'b0, b: 1'b0};
    end else if (cond_s.thermal_near) begin
      auto_rgb = '{r: 1'b1, g: 1'b1, b: 1'b1};
    end else if (cond_s.standby | low_power) begin
      auto_rgb = '{r: 1'b1, g: 1'b1, b: 1'b0};
    end else if (cond_s.disk_active) begin
      auto_rgb = '{r: 1'b0, g: 1'b0, b: 1'b1};
    end else if ((cond_s.link_10 | cond_s.link_100) & cond_s.net_active & blink_phase_reg) begin
      auto_rgb = '{r: 1'b0, g: 1'b0, b: 1'b0};
    end else if (cond_s.link_100) begin
      auto_rgb = '{r: 1'b1, g: 1'b0, b: 1'b1};
    end else if (cond_s.link_10) begin
      auto_rgb = '{r: 1'b0, g: 1'b1, b: 1'b1};
    end else begin
      auto_rgb = '{r: 1'b0, g: 1'b1, b: 1'b0};
    end
  end
  // 0x08 leaves all enables clear, so the led is dark
  assign man_rgb = '{r: led_ctrl_reg[`BLS_LED_RED_BIT],
                     g: led_ctrl_reg[`BLS_LED_GRN_BIT],
                     b: led_ctrl_reg[`BLS_LED_BLU_BIT]};
  assign led_rgb = manual_mode ? man_rgb : auto_rgb;
  // ==========================================================
  // read data
  logic [7:0] led_rd_val;
  logic [7:0] rd_next;
  assign led_rd_val = {led_ctrl_reg[7:5], ee_data_s, led_ctrl_reg[3:0]};
  assign rd_next = (io_rd_in & led_sel) ? led_rd_val :
                   (io_rd_in & rst_sel) ? rst_status : 8'h00;
  // ==========================================================
  // output flops
  logic supply_req_n;
  // supply on while the system is not in s3 or soft off
  assign supply_req_n = (pwr_reg == bls_pkg::BLS_PWR_SLEEP_S3)
                      | (pwr_reg == bls_pkg::BLS_PWR_SOFT_OFF);
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_rdata_out <= 8'h00;
      led_red_out <= 1'b0;
      led_green_out <= 1'b0;
      led_blue_out <= 1'b0;
      ee_cs_out <= 1'b0;
      ee_sk_out <= 1'b0;
      ee_di_out <= 1'b0;
      supply_on_request_n_out <= 1'b0;
      supply_on_request_n_oe_out <= 1'b1;
      power_good_out <= 1'b0;
      power_state_out <= bls_pkg::BLS_PWR_ON;
    end else begin
      io_rdata_out <= rd_next;
      led_red_out <= led_rgb.r;
      led_green_out <= led_rgb.g;
      led_blue_out <= led_rgb.b;
      ee_cs_out <= led_ctrl_reg[`BLS_LED_EE_CS_BIT];
      ee_sk_out <= led_ctrl_reg[`BLS_LED_EE_SK_BIT];
      ee_di_out <= led_ctrl_reg[`BLS_LED_EE_DI_BIT];
      // open drain: only ever pulls low
      supply_on_request_n_out <= 1'b0;
      supply_on_request_n_oe_out <= ~supply_req_n;
      power_good_out <= supplies_ok_s & ~supply_req_n;
      power_state_out <= pwr_reg;
    end
  end
endmodule : bls_top
`default_nettype wire

// ---- verif/bls_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// port checks of the status block
module bls_asserts (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // port access
  input wire logic [15:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic [7:0] io_rdata_out,
  // pins and configuration
  input wire bls_pkg::bls_rst_src_t rst_src_in,
  input wire logic power_button_in,
  input wire logic supplies_ok_in,
  input wire bls_pkg::bls_wake_t wake_in,
  input wire bls_pkg::bls_wake_t wake_en_in,
  input wire logic button_is_suspend_in,
  input wire logic s3_enable_in,
  // outputs
  input wire logic led_red_out,
  input wire logic led_green_out,
  input wire logic led_blue_out,
  input wire logic supply_on_request_n_out,
  input wire logic supply_on_request_n_oe_out,
  input wire logic power_good_out,
  input wire bls_pkg::bls_pwr_t power_state_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  wire logic led_wr = io_wr_in && io_addr_in == 16'h0456;
  wire logic st_wr = io_wr_in && io_addr_in == 16'h0457;
  wire logic st_rd = io_rd_in && io_addr_in == 16'h0457 && !st_wr;
  wire logic on_st = power_state_out == bls_pkg::BLS_PWR_ON;
  wire logic wake_go = (wake_in.dio_event && wake_en_in.dio_event) ||
    (wake_in.pm_event && wake_en_in.pm_event);
  // ==========================================================
  // sequences
  sequence s_manual;
    led_wr && io_wdata_in[3] ##1 !led_wr;
  endsequence
  // sources quiet long enough that no set can race the clear
  sequence s_clear_all;
    (rst_src_in == 7'h00) [*4] ##0 (st_wr && io_wdata_in == 8'hff) ##2 st_rd;
  endsequence
  sequence s_read_pair;
    st_rd ##1 !st_wr ##1 st_rd;
  endsequence
  // ==========================================================
  // assertions
  a_manual_led:
  assert property (s_manual |=>
    {led_red_out, led_green_out, led_blue_out} == $past(io_wdata_in[2:0], 2))
  else $error("manual led value not shown");
  a_clear_all:
  assert property (s_clear_all |=> io_rdata_out == 8'h00)
  else $error("status not cleared by write one");
  a_reserved_bit:
  assert property (st_rd |=> !io_rdata_out[2])
  else $error("reserved status bit reads one");
  a_sticky_bits:
  assert property (s_read_pair |=>
    (io_rdata_out & $past(io_rdata_out, 2)) == $past(io_rdata_out, 2))
  else $error("status bit lost without clear");
  a_standby_spread:
  assert property (rst_src_in.standby_supply [*5] ##0 st_rd |=>
    (io_rdata_out & 8'hfa) == 8'hfa)
  else $error("standby reset not spread");
  a_suspend_s3:
  assert property (on_st && button_is_suspend_in && s3_enable_in && $rose(power_button_in)
    |-> ##[1:8] power_state_out == bls_pkg::BLS_PWR_SLEEP_S3)
  else $error("suspend press did not sleep");
  a_event_wake:
  assert property (!on_st && wake_go |-> ##[1:8] on_st)
  else $error("enabled wake event ignored");
  a_supply_drive:
  assert property (on_st [*2] |-> supply_on_request_n_oe_out && !supply_on_request_n_out)
  else $error("supply request not driven");
  a_pgood_gate:
  assert property ((!supplies_ok_in) [*4] |-> !power_good_out)
  else $error("power good with bad supply");
endmodule : bls_asserts
bind bls_top bls_asserts u_asserts (
  .clock_in, .rst_n_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in,
  .io_rdata_out, .rst_src_in, .power_button_in, .supplies_ok_in, .wake_in,
  .wake_en_in, .button_is_suspend_in, .s3_enable_in, .led_red_out,
  .led_green_out, .led_blue_out, .supply_on_request_n_out,
  .supply_on_request_n_oe_out, .power_good_out, .power_state_out
);
`default_nettype wire

// ---- verif/test_board_led_and_reset_status.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
// ==========================================================
// bench for the led and reset status block
module test_board_led_and_reset_status;
  logic clock_in, rst_n_in, io_wr_in, io_rd_in, ee_data_in, jumper, button, sup_ok;
  logic btn_rst, btn_susp, s1_en, s3_en, soft_off, probe, rd_seen, pr_seen;
  logic [15:0] io_addr_in, lfsr;
  logic [7:0] io_wdata_in, rdata;
  logic [6:0] cond, src;
  logic [3:0] wake, wake_en;
  logic [2:0] ee_exp;
  logic [10:0] note;
  logic ee_cs, ee_sk, ee_di, red, green, blue, son_n, son_oe, pgood;
  bls_pkg::bls_pwr_t pstate;
  logic [10:0] exp_q[$];
  int mismatches, samples_checked;
  logic [2:0] auto_rgb [6] = '{3'b100, 3'b110, 3'b111, 3'b001, 3'b011, 3'b101};
  logic [7:0] src_exp [7] = '{8'hf2, 8'h42, 8'h22, 8'h12, 8'hfa, 8'h02, 8'h01};
  bls_top dut (
    .clock_in, .rst_n_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in,
    .io_rdata_out(rdata), .ee_data_in, .ee_cs_out(ee_cs), .ee_sk_out(ee_sk),
    .ee_di_out(ee_di), .cond_in(cond), .default_settings_jumper_in(jumper),
    .rst_src_in(src), .power_button_in(button), .supplies_ok_in(sup_ok),
    .wake_in(wake), .button_is_reset_in(btn_rst), .button_is_suspend_in(btn_susp),
    .s1_enable_in(s1_en), .s3_enable_in(s3_en), .soft_off_req_in(soft_off),
    .wake_en_in(wake_en), .led_red_out(red), .led_green_out(green),
    .led_blue_out(blue), .supply_on_request_n_out(son_n),
    .supply_on_request_n_oe_out(son_oe), .power_good_out(pgood),
    .power_state_out(pstate)
  );
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // ==========================================================
  // monitor: oldest note against whatever result just showed
  always @(posedge clock_in) begin
    rd_seen <= io_rd_in;
    pr_seen <= probe;
  end
  always @(negedge clock_in) begin
    if (rd_seen || pr_seen) begin
      note = exp_q.pop_front();
      if (note[10]) `CHK({pstate, son_oe, pgood, ee_cs, ee_sk, ee_di, red, green, blue}, note[9:0])
      else `CHK(rdata, note[7:0])
    end
  end
  // ==========================================================
  // drivers, all changes on the falling edge
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask : cyc
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_in);
    io_wr_in = 1'b1;
    io_addr_in = a;
    io_wdata_in = d;
    @(negedge clock_in);
    io_wr_in = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back({3'b000, e});
    @(negedge clock_in);
    io_rd_in = 1'b1;
    io_addr_in = a;
    @(negedge clock_in);
    io_rd_in = 1'b0;
  endtask : rd
  task automatic look(input bls_pkg::bls_pwr_t ps, input logic oe, pg, input logic [2:0] c);
    exp_q.push_back({1'b1, ps, oe, pg, ee_exp, c});
    @(negedge clock_in);
    probe = 1'b1;
    @(negedge clock_in);
    probe = 1'b0;
  endtask : look
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // hang guard, far beyond the few hundred cycles used
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
  // ==========================================================
  // main sequence
  initial begin
    {rst_n_in, io_wr_in, io_rd_in, ee_data_in, jumper, button, soft_off, s1_en} = '0;
    {probe, rd_seen, pr_seen, io_addr_in, io_wdata_in, cond, src, wake, ee_exp} = '0;
    {sup_ok, btn_rst, btn_susp, s3_en, wake_en} = 8'hff;
    {mismatches, samples_checked} = '0;
    lfsr = 16'ha772;
    cyc(10);
    rst_n_in = 1'b1;
    cyc(6);
    rd(16'h0456, 8'h00);
    rd(16'h0457, 8'h00);
    rd(16'h0458, 8'h00);
    look(bls_pkg::BLS_PWR_ON, 1'b1, 1'b1, 3'b010);
    for (int i = 0; i < 6; i++) begin
      cond = 7'h40 >> i;
      cyc(5);
      look(bls_pkg::BLS_PWR_ON, 1'b1, 1'b1, auto_rgb[i]);
    end
    cond = '0;
    for (int v = 8; v < 16; v++) begin
      lfsr = lfsr_step(lfsr);
      ee_data_in = lfsr[8];
      ee_exp = lfsr[7:5];
      wr(16'h0456, {lfsr[7:4], 1'b1, v[2:0]});
      look(bls_pkg::BLS_PWR_ON, 1'b1, 1'b1, v[2:0]);
      rd(16'h0456, {lfsr[7:5], lfsr[8], 1'b1, v[2:0]});
    end
    ee_exp = 3'b000;
    wr(16'h0456, 8'h00);
    look(bls_pkg::BLS_PWR_ON, 1'b1, 1'b1, 3'b010);
    for (int i = 0; i < 7; i++) begin
      src = 7'h40 >> i;
      cyc(6);
      rd(16'h0457, src_exp[i]);
      src = '0;
      cyc(5);
      wr(16'h0457, 8'hff);
      rd(16'h0457, 8'h00);
    end
    btn_rst = 1'b0;
    src = 7'h01;
    cyc(6);
    src = '0;
    cyc(5);
    rd(16'h0457, 8'h00);
    btn_rst = 1'b1;
    src = 7'h04;
    cyc(6);
    wr(16'h0457, 8'h0a);
    rd(16'h0457, 8'hfa);
    src = '0;
    cyc(5);
    wr(16'h0457, 8'h0a);
    rd(16'h0457, 8'hf0);
    wr(16'h0457, 8'h00);
    rd(16'h0457, 8'hf0);
    rd(16'h0457, 8'hf0);
    wr(16'h0457, 8'hff);
    wr(16'h0456, 8'h08);
    for (int k = 0; k < 2; k++) begin
      button = 1'b1;
      cyc(3);
      button = 1'b0;
      cyc(8);
      look(k ? bls_pkg::BLS_PWR_SLEEP_S1 : bls_pkg::BLS_PWR_SLEEP_S3, k[0], k[0], 3'b000);
      wake_en = 4'h7;
      wake = 4'h8;
      cyc(8);
      look(k ? bls_pkg::BLS_PWR_SLEEP_S1 : bls_pkg::BLS_PWR_SLEEP_S3,
           k[0], k[0], 3'b000);
      wake = k ? 4'h8 : 4'h1;
      wake_en = 4'hf;
      cyc(8);
      wake = '0;
      look(bls_pkg::BLS_PWR_ON, 1'b1, 1'b1, 3'b000);
      {s3_en, s1_en} = 2'b01;
    end
    soft_off = 1'b1;
    cyc(1);
    soft_off = 1'b0;
    wake = 4'h8;
    cyc(8);
    look(bls_pkg::BLS_PWR_SOFT_OFF, 1'b0, 1'b0, 3'b000);
    wake = 4'h2;
    cyc(8);
    wake = '0;
    look(bls_pkg::BLS_PWR_ON, 1'b1, 1'b1, 3'b000);
    sup_ok = 1'b0;
    cyc(6);
    look(bls_pkg::BLS_PWR_ON, 1'b1, 1'b0, 3'b000);
    sup_ok = 1'b1;
    cyc(4);
    // power-up with the jumper fitted: auto colour turns red
    jumper = 1'b1;
    rst_n_in = 1'b0;
    cyc(2);
    rst_n_in = 1'b1;
    cyc(6);
    look(bls_pkg::BLS_PWR_ON, 1'b1, 1'b1, 3'b100);
    end_sim();
  end
endmodule : test_board_led_and_reset_status
`default_nettype wire
